// ---- pt32_ctl_if.sv ----
`timescale 1ns/1ps
// Control view passed from the register file to the counting core
interface pt32_ctl_if;
	logic        run;
	logic        preClr;
	logic [1:0]  prescale;
	logic        clkSrc;
	logic        gateEn;
	logic        cycleTick;
	logic        extRise;
	logic        extFall;
	logic        extLevel;
	logic        preTick;
	modport core (input run, preClr, prescale, clkSrc, gateEn, cycleTick,
		extRise, extFall, extLevel, output preTick);
	modport regs (output run, preClr, prescale, clkSrc, gateEn, cycleTick,
		extRise, extFall, extLevel, input preTick);
endinterface

// ---- pt32_ext_src.sv ----
`timescale 1ns/1ps
// Far-side source of the external count or gate pin
module pt32_ext_src (
	input  wire logic       mclk,
	input  wire logic       go,
	input  wire logic       gateHi,
	input  wire logic [3:0] halfCyc,
	output logic            extPin
);
	logic [3:0] cnt_ff;

	initial begin
		extPin = 1'b0;
		cnt_ff = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// slow enough to sync
	// Square wave while go, else the gate level; each half lasts halfCyc + 1 clocks
	always @(posedge mclk) begin
		if (!go) begin
			extPin <= gateHi;
			cnt_ff <= 4'h0;
		end else if (cnt_ff >= halfCyc) begin
			extPin <= !extPin;
			cnt_ff <= 4'h0;
		end else begin
			cnt_ff <= cnt_ff + 4'h1;
		end
	end
endmodule

// ---- pt32_pkg.sv ----
package pt32_pkg;

	// Byte addresses of the register words on APB
	localparam logic [7:0] ADDR_LOWER_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_UPPER_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_LOWER_COUNT  = 8'h08;
	localparam logic [7:0] ADDR_UPPER_COUNT  = 8'h0c;
	localparam logic [7:0] ADDR_UPPER_HOLD   = 8'h10;
	localparam logic [7:0] ADDR_LOWER_PERIOD = 8'h14;
	localparam logic [7:0] ADDR_UPPER_PERIOD = 8'h18;
	localparam logic [7:0] ADDR_IRQ_CTRL     = 8'h1c;
	localparam logic [7:0] ADDR_STATUS       = 8'h20;

	// Control register field positions
	localparam int BIT_RUN_ENABLE   = 15;
	localparam int BIT_STOP_IN_IDLE = 13;
	localparam int BIT_GATE_ENABLE  = 6;
	localparam int BIT_PRESCALE_HI  = 5;
	localparam int BIT_PRESCALE_LO  = 4;
	localparam int BIT_PAIR_MODE    = 3;
	localparam int BIT_CLOCK_SRC    = 1;

	// Interrupt control register: flag, enable, priority
	localparam int BIT_IRQ_FLAG    = 0;
	localparam int BIT_IRQ_ENABLE  = 1;
	localparam int BIT_IRQ_PRIO_LO = 4;
	localparam int BIT_IRQ_PRIO_HI = 6;
	// Lower timer's own flag and enable, ignored while paired
	localparam int BIT_LOWER_FLAG   = 8;
	localparam int BIT_LOWER_ENABLE = 9;

	// Reset values
	localparam logic [15:0] CTRL_RESET   = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;

	// Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
	localparam logic [7:0] PRE_DIV1   = 8'h00;
	localparam logic [7:0] PRE_DIV8   = 8'h07;
	localparam logic [7:0] PRE_DIV64  = 8'h3f;
	localparam logic [7:0] PRE_DIV256 = 8'hff;

	// Instruction cycle clock divider from mclk (1 = every mclk)
	localparam logic [3:0] CYCLE_DIV = 4'h1;

	// Operating modes
	typedef enum logic [1:0] {
		PT32_TIMER   = 2'b00,
		PT32_GATED   = 2'b01,
		PT32_COUNTER = 2'b10
	} pt32_mode_t;

endpackage

// ---- pt32_prescaler.sv ----
`timescale 1ns/1ps
module pt32_prescaler
	import pt32_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	pt32_ctl_if.core  ctl
);

	typedef struct packed {
		logic [7:0] cnt;
		logic       tick;
		logic       extArmed;
	} pt32_pre_t;

	pt32_pre_t cur_ff;
	pt32_pre_t nxt_cur;
	logic      srcEdge;
	logic [7:0] term;

	// Clock source select and terminal count
	always_comb begin
		unique case (ctl.prescale)
			2'b00: term = PRE_DIV1;
			2'b01: term = PRE_DIV8;
			2'b10: term = PRE_DIV64;
			2'b11: term = PRE_DIV256;
		endcase
		// [RULE6] source per mode
		if (ctl.clkSrc) begin
			srcEdge = ctl.extRise;
		end else if (ctl.gateEn) begin
			srcEdge = ctl.cycleTick & ctl.extLevel;
		end else begin
			srcEdge = ctl.cycleTick;
		end
	end

	// Divider; first external edge only arms the counter
	always_comb begin
		nxt_cur = cur_ff;
		nxt_cur.tick = 1'b0;
		// [RULE12] prescaler clear
		if (ctl.preClr || !ctl.run) begin
			nxt_cur.cnt = 8'h00;
			nxt_cur.extArmed = 1'b0;
		end else if (srcEdge) begin
			// [RULE21] skip first external rising edge
			if (ctl.clkSrc && !cur_ff.extArmed) begin
				nxt_cur.extArmed = 1'b1;
			end else if (cur_ff.cnt == term) begin
				// [RULE11] divide ratio reached
				nxt_cur.cnt = 8'h00;
				nxt_cur.tick = 1'b1;
			end else begin
				nxt_cur.cnt = cur_ff.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign ctl.preTick = cur_ff.tick;

endmodule

// ---- pt32_timer.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// [RULE1] Pair mode bit 3 joins upper and lower into one 32-bit count.
// [RULE2] When paired, lower control steers; upper control only gives idle stop.
// [RULE3] Paired, upper interrupt flag, enable, priority act; lower ones inert.
// [RULE4] Fixed pairs only; this instance is one even/odd pair, even is low.
// [RULE5] Three modes: timer, gated timer, synchronous counter.
// [RULE6] Timer and gated use cycle clock; counter uses external pin.
// [RULE7] Source bit 1 and gate bit 6 choose the mode.
// [RULE8] External input always passes a synchroniser; no async mode.
// [RULE9] Count resets on the input clock edge after period match.
// [RULE10] Flag sets one cycle after match is detected.
// [RULE11] Prescaler ratios 1, 8, 64, 256 from bits 5:4.
// [RULE12] Prescaler clears on count write, control write, stop, reset.
// [RULE13] Run bit 15 starts and stops the whole pair.
// [RULE14] Holding register works only while paired.
// [RULE15] Reading lower count copies upper count into holding register.
// [RULE16] Software reads lower first, then holding, for coherent value.
// [RULE17] Write holding first; lower write moves holding into upper.
// [RULE18] Match raises interrupt; gated mode raises it on gate fall.
// [RULE19] Zero period with timer running never raises an interrupt.
// [RULE20] In idle, pair runs only if both stop-in-idle bits are clear.
// [RULE21] Counter mode starts on second external rising edge.
// [RULE22] Upper word advances on lower wrap; match uses 32-bit period.
// [RULE23] Software stops both timers before setting pair mode.
module pt32_timer
	import pt32_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        lowerExtClockIn,
	input  wire logic        idleReq,
	output logic             pairIrq,
	output logic [2:0]       pairIrqPriority
);

	// The lower word is the even timer of the pair, the upper the odd
	// one; other pairings cannot be built from this block
	// [RULE4] one fixed pair
	typedef struct packed {
		logic [15:0] lowerCtrl;
		logic [15:0] upperCtrl;
		logic [15:0] lowerCount;
		logic [15:0] upperCount;
		logic [15:0] upperHold;
		logic [15:0] lowerPeriod;
		logic [15:0] upperPeriod;
		logic        pairFlag;
		logic        pairEnable;
		logic [2:0]  pairPrio;
		logic        lowerFlag;
		logic        lowerEnable;
		logic        matchPend;
		logic        wrapPend;
		logic [1:0]  extSync;
		logic        extLast;
		logic [1:0]  idleSync;
		logic [3:0]  divCnt;
		logic        cycleTick;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        irqOut;
		logic [2:0]  prioOut;
	} pt32_state_t;

	pt32_state_t cur_ff;
	pt32_state_t nxt_cur;
	pt32_ctl_if  ctl ();

	logic        pairMode;
	logic        runEnable;
	logic        stopIdle;
	logic        inIdle;
	logic        accessRd;
	logic        accessWr;
	logic [31:0] fullCount;
	logic [31:0] fullPeriod;
	logic        periodMatch;
	pt32_mode_t  mode;

	////////////////////////////////////////////////////////////////////////////
	// Decoded control
	// [RULE1] pair bit decode
	assign pairMode  = cur_ff.lowerCtrl[BIT_PAIR_MODE];
	// Run, gate and prescale bits written to the upper word do nothing
	// [RULE2] upper control ignored
	// [RULE13] single run enable
	assign runEnable = cur_ff.lowerCtrl[BIT_RUN_ENABLE];
	// Idle request is asynchronous; only its second stage is read
	// [RULE20] either idle stop bit halts the pair in idle
	assign stopIdle  = cur_ff.lowerCtrl[BIT_STOP_IN_IDLE]
		| (pairMode & cur_ff.upperCtrl[BIT_STOP_IN_IDLE]);
	assign inIdle    = cur_ff.idleSync[1] & stopIdle;
	assign accessRd  = psel & penable & ~pwrite;
	assign accessWr  = psel & penable & pwrite;
	// Unpaired, the upper halves read as zero so one compare serves both
	// [RULE22] full count and period
	assign fullCount  = pairMode ? {cur_ff.upperCount, cur_ff.lowerCount}
		: {16'h0000, cur_ff.lowerCount};
	assign fullPeriod = pairMode ? {cur_ff.upperPeriod, cur_ff.lowerPeriod}
		: {16'h0000, cur_ff.lowerPeriod};
	// [RULE19] zero period never matches
	assign periodMatch = (fullCount == fullPeriod) && (fullPeriod != 32'h0);

	// Each mode behaves as a lone timer would; only the width differs
	// [RULE5] three operating modes
	// [RULE7] mode from source and gate bits
	always_comb begin
		if (cur_ff.lowerCtrl[BIT_CLOCK_SRC]) begin
			mode = PT32_COUNTER;
		end else if (cur_ff.lowerCtrl[BIT_GATE_ENABLE]) begin
			mode = PT32_GATED;
		end else begin
			mode = PT32_TIMER;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Prescaler hookup; idle holds it stopped like a clear run bit
	assign ctl.run       = runEnable & ~inIdle;
	assign ctl.prescale  = cur_ff.lowerCtrl[BIT_PRESCALE_HI:BIT_PRESCALE_LO];
	assign ctl.clkSrc    = mode == PT32_COUNTER;
	assign ctl.gateEn    = mode == PT32_GATED;
	assign ctl.cycleTick = cur_ff.cycleTick;
	// [RULE8] edges only from the second synchroniser stage
	assign ctl.extLevel  = cur_ff.extSync[1];
	assign ctl.extRise   = cur_ff.extSync[1] & ~cur_ff.extLast;
	assign ctl.extFall   = ~cur_ff.extSync[1] & cur_ff.extLast;
	// Only the first access edge clears, so one write clears once
	// [RULE12] register writes that clear the prescaler
	assign ctl.preClr    = accessWr & ~cur_ff.pready
		& (paddr == ADDR_LOWER_COUNT || paddr == ADDR_LOWER_CTRL);

	pt32_prescaler u_pre (
		.mclk (mclk),
		.rst  (rst),
		.ctl  (ctl)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next state: counting, interrupts and the register file
	always_comb begin
		nxt_cur = cur_ff;
		// Synchronisers; the first stage feeds only the second
		// Pin pulses shorter than one clock may be missed entirely
		nxt_cur.extSync  = {cur_ff.extSync[0], lowerExtClockIn};
		nxt_cur.extLast  = cur_ff.extSync[1];
		nxt_cur.idleSync = {cur_ff.idleSync[0], idleReq};
		// Instruction cycle enable
		// Held at one, the divider ticks on every clock
		if (cur_ff.divCnt >= CYCLE_DIV - 4'h1) begin
			nxt_cur.divCnt = 4'h0;
			nxt_cur.cycleTick = 1'b1;
		end else begin
			nxt_cur.divCnt = cur_ff.divCnt + 4'h1;
			nxt_cur.cycleTick = 1'b0;
		end

		// Counting on each prescaled tick
		if (ctl.preTick && ctl.run) begin
			// A matched count waits for the next input tick before it
			// clears, so the first interval is one tick short of later
			// ones; software needing even spacing drops the first event
			// [RULE9] reset on next tick
			if (periodMatch) begin
				nxt_cur.lowerCount = COUNT_RESET;
				if (pairMode) begin
					nxt_cur.upperCount = COUNT_RESET;
				end
			end else begin
				// Carry lands in the clock the low word rolls over
				// [RULE22] carry into upper word
				nxt_cur.lowerCount = cur_ff.lowerCount + 16'h0001;
				if (pairMode && cur_ff.lowerCount == 16'hffff) begin
					nxt_cur.upperCount = cur_ff.upperCount + 16'h0001;
				end
			end
		end
		// Match edge detector: a count parked on the period value under a
		// slow prescaler must raise one event, not one per clock
		nxt_cur.matchPend = periodMatch && runEnable;
		// [RULE10] flag one cycle after detection
		nxt_cur.wrapPend = periodMatch && runEnable && !cur_ff.matchPend
			&& mode != PT32_GATED;

		////////////////////////////////////////////////////////////////////////
		// APB slave: one wait state, answer in the second access cycle
		// The registered answer costs a cycle per access but keeps the
		// read mux off the bus outputs; registers update at the first
		// access edge, while the master still holds the request
		nxt_cur.pready  = 1'b0;
		nxt_cur.pslverr = 1'b0;
		if (psel && penable && !cur_ff.pready) begin
			nxt_cur.pready = 1'b1;
			nxt_cur.prdata = 32'h0;
			unique case (paddr)
				ADDR_LOWER_CTRL: begin
					nxt_cur.prdata[15:0] = cur_ff.lowerCtrl;
					// Pairing is not guarded while counting;
					// stray counts follow unless the lower run bit is clear
					// [RULE23] stop before pairing
					if (pwrite) begin
						nxt_cur.lowerCtrl = pwdata[15:0];
					end
				end
				ADDR_UPPER_CTRL: begin
					nxt_cur.prdata[15:0] = cur_ff.upperCtrl;
					if (pwrite) begin
						nxt_cur.upperCtrl = pwdata[15:0];
					end
				end
				ADDR_LOWER_COUNT: begin
					nxt_cur.prdata[15:0] = cur_ff.lowerCount;
					// Both halves come from one state word, so a
					// carry in this very cycle cannot split them
					// [RULE15] snapshot upper on lower read
					if (accessRd && pairMode) begin
						nxt_cur.upperHold = cur_ff.upperCount;
					end
					if (pwrite) begin
						nxt_cur.lowerCount = pwdata[15:0];
						// [RULE17] holding moves into upper
						if (pairMode) begin
							nxt_cur.upperCount = cur_ff.upperHold;
						end
					end
				end
				ADDR_UPPER_COUNT: begin
					nxt_cur.prdata[15:0] = cur_ff.upperCount;
					if (pwrite) begin
						nxt_cur.upperCount = pwdata[15:0];
					end
				end
				ADDR_UPPER_HOLD: begin
					// Unpaired, it reads zero and drops writes
					// [RULE14] holding active only when paired
					nxt_cur.prdata[15:0] = pairMode ? cur_ff.upperHold
						: 16'h0000;
					if (pwrite && pairMode) begin
						nxt_cur.upperHold = pwdata[15:0];
					end
				end
				ADDR_LOWER_PERIOD: begin
					nxt_cur.prdata[15:0] = cur_ff.lowerPeriod;
					if (pwrite) begin
						nxt_cur.lowerPeriod = pwdata[15:0];
					end
				end
				ADDR_UPPER_PERIOD: begin
					nxt_cur.prdata[15:0] = cur_ff.upperPeriod;
					if (pwrite) begin
						nxt_cur.upperPeriod = pwdata[15:0];
					end
				end
				ADDR_IRQ_CTRL: begin
					nxt_cur.prdata[BIT_IRQ_FLAG]   = cur_ff.pairFlag;
					nxt_cur.prdata[BIT_IRQ_ENABLE] = cur_ff.pairEnable;
					nxt_cur.prdata[BIT_IRQ_PRIO_HI:BIT_IRQ_PRIO_LO] =
						cur_ff.pairPrio;
					nxt_cur.prdata[BIT_LOWER_FLAG]   = cur_ff.lowerFlag;
					nxt_cur.prdata[BIT_LOWER_ENABLE] = cur_ff.lowerEnable;
					if (pwrite) begin
						nxt_cur.pairFlag    = pwdata[BIT_IRQ_FLAG];
						nxt_cur.pairEnable  = pwdata[BIT_IRQ_ENABLE];
						nxt_cur.pairPrio    =
							pwdata[BIT_IRQ_PRIO_HI:BIT_IRQ_PRIO_LO];
						nxt_cur.lowerFlag   = pwdata[BIT_LOWER_FLAG];
						nxt_cur.lowerEnable = pwdata[BIT_LOWER_ENABLE];
					end
				end
				ADDR_STATUS: begin
					// Read only; writes here are taken and dropped
					nxt_cur.prdata[1:0] = mode;
					nxt_cur.prdata[2]   = ctl.run;
					nxt_cur.prdata[3]   = cur_ff.extSync[1];
				end
				default: begin
					nxt_cur.pslverr = 1'b1;
				end
			endcase
		end

		////////////////////////////////////////////////////////////////////////
		// Hardware set after software access so the set wins; a clear
		// landing with a new event would otherwise lose that event
		// [RULE18] match event, or gate falling edge in gated mode
		if (cur_ff.wrapPend || (mode == PT32_GATED && ctl.extFall
				&& runEnable && !inIdle)) begin
			// [RULE3] paired events go to upper flag only
			if (pairMode) begin
				nxt_cur.pairFlag = 1'b1;
			end else begin
				nxt_cur.lowerFlag = 1'b1;
			end
		end

		// Interrupt request: pairs use upper controls, needs nonzero prio
		// Paired, a zero priority parks the source even with its enable set
		// [RULE3] upper enable and priority
		if (pairMode) begin
			nxt_cur.irqOut  = cur_ff.pairFlag & cur_ff.pairEnable
				& (cur_ff.pairPrio != 3'h0);
			nxt_cur.prioOut = cur_ff.pairPrio;
		end else begin
			nxt_cur.irqOut  = cur_ff.lowerFlag & cur_ff.lowerEnable;
			nxt_cur.prioOut = 3'h0;
		end
	end

	// State register; reset also clears the prescaler
	// Periods reset to all ones so a fresh timer never matches early
	always_ff @(posedge mclk) begin
		if (rst) begin
			cur_ff <= '0;
			cur_ff.lowerCtrl   <= CTRL_RESET;
			cur_ff.upperCtrl   <= CTRL_RESET;
			cur_ff.lowerPeriod <= PERIOD_RESET;
			cur_ff.upperPeriod <= PERIOD_RESET;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs straight from flip-flops
	// Nothing combinational reaches a pin
	assign pready          = cur_ff.pready;
	assign prdata          = cur_ff.prdata;
	assign pslverr         = cur_ff.pslverr;
	assign pairIrq         = cur_ff.irqOut;
	assign pairIrqPriority = cur_ff.prioOut;

endmodule

// ---- pt32_timer_chk.sv ----
`timescale 1ns/1ps
module pt32_timer_chk
	import pt32_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        lowerExtClockIn,
	input wire logic        idleReq,
	input wire logic        pairIrq,
	input wire logic [2:0]  pairIrqPriority
);
	logic       pairSh_ff;
	logic       enSh_ff;
	logic [2:0] prioSh_ff;
	logic       wrEv;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	// Shadow of pair bit and pair interrupt controls, updated as writes land
	assign wrEv = psel && penable && pready && pwrite;
	always_ff @(posedge mclk) begin
		if (rst) begin
			pairSh_ff <= 1'b0;
			enSh_ff   <= 1'b0;
			prioSh_ff <= 3'h0;
		end else if (wrEv && paddr == ADDR_LOWER_CTRL) begin
			pairSh_ff <= pwdata[BIT_PAIR_MODE];
		end else if (wrEv && paddr == ADDR_IRQ_CTRL) begin
			enSh_ff   <= pwdata[BIT_IRQ_ENABLE];
			prioSh_ff <= pwdata[BIT_IRQ_PRIO_HI:BIT_IRQ_PRIO_LO];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Steps of an access and of a masked pair interrupt
	sequence sAccess;
		psel && penable && !pready;
	endsequence
	sequence sMasked;
		(pairSh_ff && !(enSh_ff && prioSh_ff != 3'h0))[*3];
	endsequence

	AST_APB_ANSWER: assert property (sAccess |=> pready)
		else $error("no answer one cycle into the access");
	AST_APB_PULSE: assert property (pready |=> !pready)
		else $error("ready stood longer than one cycle");
	AST_APB_HELD: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	AST_RDATA_HI: assert property (pready |-> prdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	AST_UNMAPPED: assert property (pready && paddr > ADDR_STATUS
		|-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	AST_MAPPED: assert property (pready && paddr <= ADDR_STATUS
		&& paddr[1:0] == 2'b00 |-> !pslverr)
		else $error("mapped access refused");
	AST_RESET_QUIET: assert property ($fell(rst)
		|-> !pairIrq && !pready && pairIrqPriority == 3'h0)
		else $error("outputs not quiet after reset");
	AST_PRIO_FOLLOW: assert property (
		wrEv && paddr == ADDR_IRQ_CTRL && pairSh_ff
		|-> ##2 pairIrqPriority == prioSh_ff)
		else $error("priority output does not follow write");
	AST_PRIO_UNPAIRED: assert property (
		(!pairSh_ff)[*3] |-> pairIrqPriority == 3'h0)
		else $error("priority shown while unpaired");
	AST_IRQ_MASK: assert property (sMasked |-> !pairIrq)
		else $error("pair interrupt while masked");
endmodule

bind pt32_timer pt32_timer_chk u_chk (
	.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr), .lowerExtClockIn(lowerExtClockIn),
	.idleReq(idleReq), .pairIrq(pairIrq), .pairIrqPriority(pairIrqPriority)
);

// ---- tb.sv ----
`timescale 1ns/1ps
module tb
	import pt32_pkg::*;
;
	typedef struct packed {
		logic [32:0] mask;
		logic [32:0] val;
	} pt32_exp_t;
	localparam logic [32:0] ALL = {33{1'b1}};
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        idleReq = 1'b0;
	logic        go = 1'b0;
	logic        gateHi = 1'b0;
	logic [3:0]  halfCyc = 4'h2;
	logic        pready;
	logic        pslverr;
	logic        pairIrq;
	logic        extPin;
	logic [31:0] prdata;
	logic [2:0]  pairIrqPriority;
	logic [15:0] rnd = 16'h0004;
	logic [15:0] hv;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          t1;
	int          t2;
	int          divs [4] = '{1, 8, 64, 256};
	pt32_exp_t   e;
	pt32_exp_t   expQ [$];

	pt32_timer u_dut (
		.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .lowerExtClockIn(extPin),
		.idleReq(idleReq), .pairIrq(pairIrq),
		.pairIrqPriority(pairIrqPriority)
	);
	pt32_ext_src u_ext (
		.mclk(mclk), .go(go), .gateHi(gateHi), .halfCyc(halfCyc),
		.extPin(extPin)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock and cycle count
	always #10 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	// One APB transfer; waits for ready with a bound, no fixed latency
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (n >= 40) n_mismatch++;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		xfer(1'b1, a, {16'h0000, d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] v,
		input logic [32:0] m);
		expQ.push_back('{m, v});
		xfer(1'b0, a, 32'h0);
	endtask

	// Waits for a fresh rise: a still-high flag must drop first
	task automatic wait_irq(output int t);
		int n;
		n = 0;
		while (pairIrq !== 1'b0 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		while (pairIrq !== 1'b1 && n < 9000) begin
			@(posedge mclk);
			n++;
		end
		chk({32'h0, pairIrq}, 33'h1);
		t = cyc;
	endtask

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Read monitor: oldest note against each answered read
	always @(posedge mclk) begin
		if (psel && penable && !pwrite && pready === 1'b1) begin
			e = expQ.pop_front();
			chk({pslverr, prdata} & e.mask, e.val & e.mask);
		end
	end

	// Watchdog, well past the longest expected run
	initial begin
		repeat (60000) @(posedge mclk);
		n_mismatch++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			rd(8'(4 * i), (i == 5 || i == 6) ? {17'h0, PERIOD_RESET} : 33'h0,
				ALL);
		end
		rd(8'h24, {1'b1, 32'h0}, ALL);
		wr(8'h28, 16'hffff);
		rnd = lfsr(rnd);
		wr(ADDR_UPPER_HOLD, rnd);
		wr(ADDR_LOWER_COUNT, 16'h0000);
		rd(ADDR_UPPER_COUNT, 33'h0, ALL);
		wr(ADDR_LOWER_CTRL, 16'h0008);
		rnd = lfsr(rnd);
		hv = rnd;
		wr(ADDR_UPPER_HOLD, hv);
		wr(ADDR_LOWER_COUNT, 16'hfff0);
		rd(ADDR_UPPER_COUNT, {17'h0, hv}, ALL);
		wr(ADDR_LOWER_CTRL, 16'h8008);
		repeat (30) @(posedge mclk);
		wr(ADDR_LOWER_CTRL, 16'h0008);
		rd(ADDR_LOWER_COUNT, 33'h0, {1'b1, 32'h0});
		rd(ADDR_UPPER_HOLD, {17'h0, hv + 16'h0001}, ALL);
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_LOWER_CTRL, 16'h0008 | 16'(i[0]) << 6 | 16'(i[1]) << 1);
			rd(ADDR_STATUS, {31'h0, i[1], !i[1] && i[0]}, 33'h3);
		end
		// ratio sweep; match interval is (period + 1) input ticks
		wr(ADDR_UPPER_HOLD, 16'h0000);
		wr(ADDR_UPPER_PERIOD, 16'h0000);
		wr(ADDR_LOWER_PERIOD, 16'h000f);
		foreach (divs[k]) begin
			wr(ADDR_LOWER_CTRL, 16'h0008);
			wr(ADDR_LOWER_COUNT, 16'h0000);
			wr(ADDR_IRQ_CTRL, 16'h0012);
			wr(ADDR_LOWER_CTRL, 16'h8008 | 16'(k) << 4);
			wait_irq(t1);
			wr(ADDR_IRQ_CTRL, 16'h0012);
			wait_irq(t2);
			chk(33'(t2 - t1), 33'(16 * divs[k]));
		end
		wr(ADDR_IRQ_CTRL, 16'h0300);
		repeat (40) @(posedge mclk);
		chk({32'h0, pairIrq}, 33'h0);
		wr(ADDR_LOWER_CTRL, 16'h0008);
		wr(ADDR_LOWER_PERIOD, 16'h0000);
		wr(ADDR_LOWER_COUNT, 16'h0000);
		wr(ADDR_IRQ_CTRL, 16'h0012);
		wr(ADDR_LOWER_CTRL, 16'h8008);
		repeat (300) @(posedge mclk);
		chk({32'h0, pairIrq}, 33'h0);
		rd(ADDR_IRQ_CTRL, 33'h0012, ALL);
		chk({30'h0, pairIrqPriority}, 33'h1);
		// gated flag on gate fall; period too long to match
		wr(ADDR_LOWER_CTRL, 16'h0048);
		wr(ADDR_UPPER_PERIOD, 16'hffff);
		wr(ADDR_LOWER_PERIOD, 16'hffff);
		wr(ADDR_LOWER_COUNT, 16'h0000);
		wr(ADDR_LOWER_CTRL, 16'h8048);
		gateHi <= 1'b1;
		repeat (20) @(posedge mclk);
		chk({32'h0, pairIrq}, 33'h0);
		gateHi <= 1'b0;
		wait_irq(t1);
		wr(ADDR_LOWER_CTRL, 16'h000a);
		wr(ADDR_UPPER_CTRL, 16'h8070);
		wr(ADDR_LOWER_COUNT, 16'h0000);
		wr(ADDR_LOWER_CTRL, 16'h800a);
		rnd = lfsr(rnd);
		halfCyc <= 4'h2 + {1'b0, rnd[2:0]};
		go <= 1'b1;
		repeat (5) @(posedge extPin);
		@(negedge extPin);
		go <= 1'b0;
		repeat (10) @(posedge mclk);
		wr(ADDR_LOWER_CTRL, 16'h000a);
		rd(ADDR_LOWER_COUNT, 33'h4, ALL);
		// idle stop from the upper word
		idleReq <= 1'b1;
		wr(ADDR_UPPER_CTRL, 16'h2000);
		wr(ADDR_LOWER_COUNT, 16'h0000);
		wr(ADDR_LOWER_CTRL, 16'h8008);
		repeat (20) @(posedge mclk);
		wr(ADDR_LOWER_CTRL, 16'h0008);
		rd(ADDR_LOWER_COUNT, 33'h0, ALL);
		end_sim();
	end
endmodule
